// ===== bisg_ch_if.sv
`timescale 1ns/1ps
interface bisg_ch_if;
  logic rise;   // One-cycle rising edge event
  logic fall;   // One-cycle falling edge event
  logic level;  // Synchronised contact level
  modport src (output rise, output fall, output level);
  modport dst (input rise, input fall, input level);
endinterface

// ===== bisg_edge.sv
`timescale 1ns/1ps
module bisg_edge
  import bisg_pkg::*;
(
  // Clock, reset, enable
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic ce,
  // Contact pin
  input  wire logic pin,
  // Events
  bisg_ch_if.src    ev
);
  typedef struct packed {
    logic s1;   // First sync stage
    logic s2;   // Second sync stage
    logic s3;   // Previous level
  } bisg_edge_st_t;

  bisg_edge_st_t st_r;
  bisg_edge_st_t st_nxt;

  // Shift chain
  always_comb begin
    st_nxt = st_r;
    if (ce) begin
      st_nxt.s1 = pin;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
    end
  end

  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Edges only from the second stage onward
  assign ev.rise  = ce & st_r.s2 & ~st_r.s3;
  assign ev.fall  = ce & ~st_r.s2 & st_r.s3;
  assign ev.level = st_r.s2;

  property p_one_pulse;
    @(posedge clk) disable iff (!nrst) ev.rise |=> !ev.rise;
  endproperty
  a_one_pulse: assert property (p_one_pulse) else $error("rise pulse too long");
endmodule // bisg_edge

// ===== bisg_far_model.sv
`timescale 1ns/1ps
module bisg_far_model
  import bisg_pkg::*;
(
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            nrst,
  // Contact commands from the bench and contact pins
  input  wire logic [1:0]      press,
  output logic      [1:0]      pin,
  // Telegram requests from the block
  input  wire logic [1:0]      tx_req,
  input  wire logic [1:0]      tx_val,
  input  wire logic [1:0]      tx_cyc,
  // Counter clear
  input  wire logic            clr,
  // Observed telegrams
  output logic [1:0][7:0]      n_req,
  output logic [1:0][7:0]      n_cyc,
  output logic      [1:0]      last_val
);
  // Potential-free contacts, closed reads high
  assign pin = press;

  // Transmitter side: count every request outside a clear cycle and keep its value
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      n_req    <= '0;
      n_cyc    <= '0;
      last_val <= 2'h0;
    end else if (clr) begin
      n_req    <= '0;
      n_cyc    <= '0;
    end else begin
      for (int i = 0; i < BISG_NCH; i++) begin
        if (tx_req[i]) begin
          n_req[i]    <= n_req[i] + 8'h01;
          last_val[i] <= tx_val[i];
        end
        if (tx_cyc[i]) n_cyc[i] <= n_cyc[i] + 8'h01;
      end
    end
  end
endmodule // bisg_far_model

// ===== bisg_pkg.sv
package bisg_pkg;
  // Channel count and reaction encoding
  localparam int          BISG_NCH        = 2;
  localparam logic [1:0]  BISG_RX_NONE    = 2'h0;
  localparam logic [1:0]  BISG_RX_OFF     = 2'h1;
  localparam logic [1:0]  BISG_RX_ON      = 2'h2;
  localparam logic [1:0]  BISG_RX_TOGGLE  = 2'h3;
  // Register offsets
  localparam logic [3:0]  BISG_A_CTRL     = 4'h0;
  localparam logic [3:0]  BISG_A_CH0      = 4'h1;
  localparam logic [3:0]  BISG_A_CH1      = 4'h2;
  localparam logic [3:0]  BISG_A_DELAY    = 4'h3;
  localparam logic [3:0]  BISG_A_STAT     = 4'h4;
  // Control fields
  localparam int          BISG_CTRL_RLIM  = 0;
  localparam int          BISG_CTRL_RST   = 1;
  // Channel config fields: [1:0] rise, [3:2] fall, [5:4] bus return, [6] forced
  localparam int          BISG_CF_RISE    = 0;
  localparam int          BISG_CF_FALL    = 2;
  localparam int          BISG_CF_RET     = 4;
  localparam int          BISG_CF_FORCE   = 6;
  localparam logic [7:0]  BISG_CFG_RST    = 8'h00;
  localparam logic [15:0] BISG_DELAY_RST  = 16'h0000;
  // Timing
  localparam int          BISG_CLK_MHZ    = 100;
  localparam int          BISG_MS_CYC     = BISG_CLK_MHZ * 1000;
  localparam int          BISG_RLIM_S     = 17;
  localparam int          BISG_RLIM_MS    = BISG_RLIM_S * 1000;
endpackage

// ===== bisg_top.sv
`timescale 1ns/1ps
//Contract
// - Two inputs, each evaluated independently
// - Per-channel reaction config for edges, return
// - Request from level or forced command
// - No reaction before startup delay ends
// - Edges during delay discarded, not queued
// - One shared startup delay value
// - Rate limit blocks telegrams first 17s
// - Return reaction dropped if delay ends early
// - Single rate-limit enable for both inputs
// - Rate limit gates input and periodic telegrams
// - Periodic sends start after 17s limit
module bisg_top
  import bisg_pkg::*;
#(
  parameter int RLIM_CYC = BISG_RLIM_MS * BISG_MS_CYC,  // 17 s in cycles
  parameter int MS_CYC   = BISG_MS_CYC                   // Cycles per ms tick
)(
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  // Bus voltage return event
  input  wire logic        bus_ret,
  // Contact pins
  input  wire logic [1:0]  pin,
  // Periodic send tick for the channels
  input  wire logic        cyc_tick,
  // Register port
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  // Telegram requests
  output logic      [1:0]  tx_req,
  output logic      [1:0]  tx_val,
  output logic      [1:0]  tx_cyc
);
  typedef enum logic [1:0] {BISG_DELAY, BISG_WAIT, BISG_RUN} bisg_ph_t;

  typedef struct packed {
    bisg_ph_t    ph;        // Startup phase
    logic        rlim;      // Rate limit enable, shared
    logic [7:0]  cfg0;      // Channel 0 config
    logic [7:0]  cfg1;      // Channel 1 config
    logic [15:0] delay;     // Shared startup delay in ms
    logic [15:0] ms_cnt;    // Elapsed ms of delay
    logic [31:0] sub_cnt;   // Cycles inside current ms
    logic [31:0] rl_cnt;    // Cycles since bus return
    logic        rl_act;    // Rate window still open
    logic [1:0]  obj;       // Switching object values
    logic [1:0]  req;       // Request strobes
    logic [1:0]  val;       // Request values
    logic [1:0]  cyc;       // Periodic send strobes
    logic [31:0] rdat;      // Read data
    logic [2:0]  br;        // Bus return sync chain, [0] first stage
  } bisg_st_t;

  bisg_st_t st_r;
  bisg_st_t st_nxt;

  // Per-channel edge detectors
  bisg_ch_if chi [BISG_NCH] ();
  logic [1:0] rise_v;
  logic [1:0] fall_v;
  logic [1:0] lvl_v;

  genvar gi;
  generate
    for (gi = 0; gi < BISG_NCH; gi++) begin : g_ch
      bisg_edge u_edge (
        .clk  (clk),
        .nrst (nrst),
        .ce   (ce),
        .pin  (pin[gi]),
        .ev   (chi[gi])
      );
      assign rise_v[gi] = chi[gi].rise;
      assign fall_v[gi] = chi[gi].fall;
      assign lvl_v[gi]  = chi[gi].level;
    end
  endgenerate

  // Bus return edge from the second and third sync stages
  logic br_ev;
  assign br_ev = st_r.br[1] & ~st_r.br[2];

  // Software restart through the control register
  logic sw_rst;
  assign sw_rst = wr && (addr == BISG_A_CTRL) && wdata[BISG_CTRL_RST];

  // Reaction decode into request and value
  function automatic logic [1:0] bisg_react(input logic [1:0] rx, input logic obj,
                                            input logic lvl, input logic force_m);
    logic [1:0] r;
    r = 2'h0;
    if (rx != BISG_RX_NONE) begin
      r[1] = 1'b1;
      if (!force_m) begin
        r[0] = lvl;
      end else begin
        unique case (rx)
          BISG_RX_OFF:    r[0] = 1'b0;
          BISG_RX_ON:     r[0] = 1'b1;
          BISG_RX_TOGGLE: r[0] = ~obj;
          default:        r[0] = 1'b0;
        endcase
      end
    end
    return r;
  endfunction

  logic [7:0] cfg_a [BISG_NCH];
  assign cfg_a[0] = st_r.cfg0;
  assign cfg_a[1] = st_r.cfg1;

  // Next state
  always_comb begin
    logic [1:0] rx;
    logic [1:0] re;
    logic       blk;
    logic       dly_done;
    rx       = 2'h0;
    re       = 2'h0;
    blk      = 1'b0;
    dly_done = 1'b0;
    st_nxt   = st_r;
    if (ce) begin
      st_nxt.req  = 2'h0;
      st_nxt.cyc  = 2'h0;
      st_nxt.rdat = 32'h0;
      // Bus return passes two flops before its edge is taken
      st_nxt.br   = {st_r.br[1:0], bus_ret};
      // Rate window counter runs from bus return
      if (st_r.rl_act) begin
        if (st_r.rl_cnt >= 32'(RLIM_CYC - 1)) begin
          st_nxt.rl_act = 1'b0;
        end else begin
          st_nxt.rl_cnt = st_r.rl_cnt + 32'h1;
        end
      end
      // One gate shared by both channels while the window is open
      blk = st_r.rlim & st_r.rl_act;
      // Startup phase sequencing
      unique case (st_r.ph)
        BISG_DELAY: begin                       // events dropped here
          // Delay counted in whole ms ticks
          dly_done = (st_r.ms_cnt >= st_r.delay);
          if (dly_done) begin
            st_nxt.ph = BISG_RUN;
            // Bus return reaction only if rate limit off or rate window closed
            if (!blk) begin
              for (int i = 0; i < BISG_NCH; i++) begin
                re = bisg_react(cfg_a[i][BISG_CF_RET +: 2], st_r.obj[i], lvl_v[i],
                                cfg_a[i][BISG_CF_FORCE]);
                st_nxt.req[i] = re[1];
                st_nxt.val[i] = re[0];
                if (re[1]) begin
                  st_nxt.obj[i] = re[0];
                end
              end
            end
          end else if (st_r.sub_cnt >= 32'(MS_CYC - 1)) begin
            st_nxt.sub_cnt = 32'h0;
            st_nxt.ms_cnt  = st_r.ms_cnt + 16'h1;
          end else begin
            st_nxt.sub_cnt = st_r.sub_cnt + 32'h1;
          end
        end
        BISG_WAIT: begin
          st_nxt.ph = BISG_RUN;
        end
        BISG_RUN: begin
          // Each channel picks its own reaction
          for (int i = 0; i < BISG_NCH; i++) begin
            rx = rise_v[i] ? cfg_a[i][BISG_CF_RISE +: 2] :
                 fall_v[i] ? cfg_a[i][BISG_CF_FALL +: 2] : BISG_RX_NONE;
            re = bisg_react(rx, st_r.obj[i], lvl_v[i], cfg_a[i][BISG_CF_FORCE]);
            if (re[1] && !blk) begin
              st_nxt.req[i] = 1'b1;
              st_nxt.val[i] = re[0];
              st_nxt.obj[i] = re[0];
            end
            if (cyc_tick && !blk) begin
              st_nxt.cyc[i] = 1'b1;
            end
          end
        end
        default: st_nxt.ph = BISG_DELAY;
      endcase
      // Bus return restarts delay and rate window
      if (br_ev || sw_rst) begin
        st_nxt.ph      = BISG_DELAY;
        st_nxt.ms_cnt  = 16'h0;
        st_nxt.sub_cnt = 32'h0;
        st_nxt.rl_cnt  = 32'h0;
        st_nxt.rl_act  = 1'b1;
        st_nxt.req     = 2'h0;
        st_nxt.cyc     = 2'h0;
      end
      // Register writes
      if (wr) begin
        unique case (addr)
          BISG_A_CTRL:  st_nxt.rlim  = wdata[BISG_CTRL_RLIM];
          BISG_A_CH0:   st_nxt.cfg0  = wdata[7:0];
          BISG_A_CH1:   st_nxt.cfg1  = wdata[7:0];
          BISG_A_DELAY: st_nxt.delay = wdata[15:0];
          default: ;
        endcase
      end
      // Register reads
      if (rd) begin
        unique case (addr)
          BISG_A_CTRL:  st_nxt.rdat = {31'h0, st_r.rlim};
          BISG_A_CH0:   st_nxt.rdat = {24'h0, st_r.cfg0};
          BISG_A_CH1:   st_nxt.rdat = {24'h0, st_r.cfg1};
          BISG_A_DELAY: st_nxt.rdat = {16'h0, st_r.delay};
          BISG_A_STAT:  st_nxt.rdat = {24'h0, st_r.obj, lvl_v, 1'b0, st_r.rl_act,
                                       st_r.ph};
          default:      st_nxt.rdat = 32'h0;
        endcase
      end
    end
  end

  // State register; reset acts as bus return
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r        <= '0;
      st_r.ph     <= BISG_DELAY;
      st_r.rl_act <= 1'b1;
      st_r.cfg0   <= BISG_CFG_RST;
      st_r.cfg1   <= BISG_CFG_RST;
      st_r.delay  <= BISG_DELAY_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata  = st_r.rdat;
  assign tx_req = st_r.req;
  assign tx_val = st_r.val;
  assign tx_cyc = st_r.cyc;

  // Checks
  // No request while the delay keeps running
  property p_no_req_delay;
    @(posedge clk) disable iff (!nrst)
      (st_r.ph == BISG_DELAY && st_nxt.ph == BISG_DELAY) |=> (tx_req == 2'h0);
  endproperty
  a_no_req_delay: assert property (p_no_req_delay) else $error("request in delay");

  // A rising edge in the delay never ends it early
  property p_no_queue;
    @(posedge clk) disable iff (!nrst)
      (st_r.ph == BISG_DELAY && (rise_v != 2'h0)) |-> (st_nxt.ph != BISG_RUN) ||
      (st_r.ms_cnt >= st_r.delay);
  endproperty
  a_no_queue: assert property (p_no_queue) else $error("edge queued");

  // Open window with limit on blocks all channel telegrams
  property p_rlim_block;
    @(posedge clk) disable iff (!nrst)
      (st_r.rlim && st_r.rl_act && ce) |=> (tx_req == 2'h0 && tx_cyc == 2'h0);
  endproperty
  a_rlim_block: assert property (p_rlim_block) else $error("telegram in rate window");

  // Delay ending inside the window drops the return reaction
  property p_ret_drop;
    @(posedge clk) disable iff (!nrst)
      (ce && st_r.ph == BISG_DELAY && st_r.ms_cnt >= st_r.delay && st_r.rlim &&
       st_r.rl_act && !br_ev && !sw_rst) |=> (tx_req == 2'h0 && st_r.ph == BISG_RUN);
  endproperty
  a_ret_drop: assert property (p_ret_drop) else $error("return reaction not dropped");

  // Periodic sends only from a cycle with the gate open
  property p_cyc_late;
    @(posedge clk) disable iff (!nrst)
      (tx_cyc != 2'h0) |-> (!$past(st_r.rlim) || !$past(st_r.rl_act));
  endproperty
  a_cyc_late: assert property (p_cyc_late) else $error("periodic send too early");

  // Forced ON on a rising edge sends ON
  property p_rise_req;
    @(posedge clk) disable iff (!nrst)
      (ce && st_r.ph == BISG_RUN && rise_v[0] && st_r.cfg0[1:0] == BISG_RX_ON &&
       st_r.cfg0[BISG_CF_FORCE] && !(st_r.rlim && st_r.rl_act) && !br_ev && !wr)
      |=> (tx_req[0] && tx_val[0]);
  endproperty
  a_rise_req: assert property (p_rise_req) else $error("rising edge lost");

  // Unforced falling edge sends the low level
  property p_level_req;
    @(posedge clk) disable iff (!nrst)
      (ce && st_r.ph == BISG_RUN && fall_v[1] && st_r.cfg1[3:2] != BISG_RX_NONE &&
       !st_r.cfg1[BISG_CF_FORCE] && !(st_r.rlim && st_r.rl_act) && !br_ev && !wr)
      |=> (tx_req[1] && !tx_val[1]);
  endproperty
  a_level_req: assert property (p_level_req) else $error("level request wrong");

  // A rising edge on channel 0 leaves channel 1 quiet
  property p_indep;
    @(posedge clk) disable iff (!nrst)
      (ce && st_r.ph == BISG_RUN && rise_v[0] && !rise_v[1] && !fall_v[1] && !cyc_tick)
      |=> !tx_req[1];
  endproperty
  a_indep: assert property (p_indep) else $error("channels not independent");

  // Restart puts the block back into the delay with the window open
  property p_restart;
    @(posedge clk) disable iff (!nrst)
      (ce && (br_ev || sw_rst)) |=>
      (st_r.ph == BISG_DELAY && st_r.rl_act && tx_req == 2'h0);
  endproperty
  a_restart: assert property (p_restart) else $error("restart not taken");

  // The shared delay holds the phase until its count is reached
  property p_delay_hold;
    @(posedge clk) disable iff (!nrst)
      (ce && st_r.ph == BISG_DELAY && st_r.ms_cnt < st_r.delay && !br_ev && !sw_rst)
      |=> (st_r.ph == BISG_DELAY);
  endproperty
  a_delay_hold: assert property (p_delay_hold) else $error("delay ended early");

  // Periodic strobes only appear in the run phase
  property p_cyc_run;
    @(posedge clk) disable iff (!nrst)
      (tx_cyc != 2'h0) |-> (st_r.ph == BISG_RUN);
  endproperty
  a_cyc_run: assert property (p_cyc_run) else $error("periodic send outside run");

  // A channel 0 request carries the value now held in its object
  property p_obj_track;
    @(posedge clk) disable iff (!nrst)
      tx_req[0] |-> (tx_val[0] == st_r.obj[0]);
  endproperty
  a_obj_track: assert property (p_obj_track) else $error("object not tracked");

  // The window stays open until its full count has run
  property p_win_open;
    @(posedge clk) disable iff (!nrst)
      (ce && st_r.rl_act && st_r.rl_cnt < 32'(RLIM_CYC - 1)) |=> st_r.rl_act;
  endproperty
  a_win_open: assert property (p_win_open) else $error("window closed early");
endmodule // bisg_top

// ===== bisg_top_tb_top.sv
`timescale 1ns/1ps
module bisg_top_tb_top;
  import bisg_pkg::*;
  localparam int RLIM = 200;  // Short rate window in cycles
  localparam int MSC  = 4;    // Cycles per ms tick
  // Bench signals
  logic            clk      = 1'b0;
  logic            nrst     = 1'b0;
  logic            ce       = 1'b1;
  logic            bus_ret  = 1'b0;
  logic            cyc_tick = 1'b0;
  logic [3:0]      addr     = 4'h0;
  logic [31:0]     wdata    = 32'h0;
  logic            wr       = 1'b0;
  logic            rd       = 1'b0;
  logic [1:0]      press    = 2'h0;
  logic            clr      = 1'b0;
  logic [31:0]     rdata;
  logic [1:0]      tx_req;
  logic [1:0]      tx_val;
  logic [1:0]      tx_cyc;
  logic [1:0]      pin;
  logic [1:0][7:0] n_req;
  logic [1:0][7:0] n_cyc;
  logic [1:0]      last_val;
  logic [31:0]     v;
  int              failures = 0;
  int              n_tests  = 0;
  int              cyc      = 0;

  // Clock at 100 MHz
  always #5 clk = ~clk;

  bisg_top #(.RLIM_CYC(RLIM), .MS_CYC(MSC)) i_bisg_top (
    .clk(clk), .nrst(nrst), .ce(ce), .bus_ret(bus_ret), .pin(pin),
    .cyc_tick(cyc_tick), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .tx_req(tx_req), .tx_val(tx_val), .tx_cyc(tx_cyc));

  bisg_far_model i_bisg_far_model (
    .clk(clk), .nrst(nrst), .press(press), .pin(pin), .tx_req(tx_req),
    .tx_val(tx_val), .tx_cyc(tx_cyc), .clr(clr), .n_req(n_req),
    .n_cyc(n_cyc), .last_val(last_val));

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Register write, one strobe cycle
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // Register read, data taken in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Contact change, then time for sync and request
  task automatic hit(input int ch, input logic lvl);
    @(posedge clk);
    press[ch] <= lvl;
    wt(10);
  endtask

  task automatic pulse_tick;
    @(posedge clk);
    cyc_tick <= 1'b1;
    @(posedge clk);
    cyc_tick <= 1'b0;
    wt(6);
  endtask

  task automatic clear;
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask

  task automatic summarize;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      summarize();
    end
  end

  // Main sequence
  initial begin
    wt(10);
    nrst <= 1'b1;
    // Reset values and an unmapped place
    for (int a = 0; a < 4; a++) begin
      rd_reg(4'(a), v);
      chk("reset value", v, 32'h0);
    end
    wr_reg(4'h5, 32'hFF);
    rd_reg(4'h5, v);
    chk("unmapped", v, 32'h0);
    // Clock enable low freezes the register file
    @(posedge clk);
    ce <= 1'b0;
    wr_reg(BISG_A_DELAY, 32'h7);
    @(posedge clk);
    ce <= 1'b1;
    rd_reg(BISG_A_DELAY, v);
    chk("frozen write", v, 32'h0);
    // Ch0 forced: rise ON, fall OFF, return ON; ch1 level on rise only
    wr_reg(BISG_A_CH0, 32'h66);
    wr_reg(BISG_A_CH1, 32'h02);
    wr_reg(BISG_A_DELAY, 32'h0A);
    rd_reg(BISG_A_CH0, v);
    chk("ch0 cfg", v, 32'h66);
    rd_reg(BISG_A_DELAY, v);
    chk("delay", v, 32'h0A);
    clear();
    wr_reg(BISG_A_CTRL, 32'h2);
    // Edges inside the 40-cycle delay
    wt(3);
    hit(0, 1'b1);
    hit(0, 1'b0);
    rd_reg(BISG_A_STAT, v);
    chk("phase delay", 32'(v[1:0]), 32'h0);
    chk("no early req", 32'(n_req[0]), 32'h0);
    wt(40);
    rd_reg(BISG_A_STAT, v);
    chk("phase run", 32'(v[1:0]), 32'h2);
    chk("ret req ch0", 32'(n_req[0]), 32'h1);
    chk("ret val ch0", 32'(last_val[0]), 32'h1);
    chk("ret none ch1", 32'(n_req[1]), 32'h0);
    hit(1, 1'b1);
    hit(1, 1'b0);
    chk("ch1 rise only", 32'(n_req[1]), 32'h1);
    chk("ch1 level", 32'(last_val[1]), 32'h1);
    // Ch1 falling edge only, unforced: the low level is sent
    wr_reg(BISG_A_CH1, 32'h04);
    hit(1, 1'b1);
    hit(1, 1'b0);
    chk("ch1 fall level", 32'({n_req[1], 7'h0, last_val[1]}), 32'h200);
    hit(0, 1'b1);
    chk("ch0 on", 32'({n_req[0], 7'h0, last_val[0]}), 32'h201);
    hit(0, 1'b0);
    chk("ch0 off", 32'({n_req[0], 7'h0, last_val[0]}), 32'h300);
    // Rate limit with delay ending inside the window; ch1 toggles
    wr_reg(BISG_A_CH1, 32'h43);
    clear();
    wr_reg(BISG_A_CTRL, 32'h3);
    wt(60);
    rd_reg(BISG_A_STAT, v);
    chk("run, window open", 32'(v[2:0]), 32'h6);
    chk("ret dropped", 32'(n_req[0]), 32'h0);
    hit(0, 1'b1);
    hit(1, 1'b1);
    pulse_tick();
    chk("held ch0", 32'(n_req[0]), 32'h0);
    chk("held ch1", 32'(n_req[1]), 32'h0);
    chk("no cyclic", 32'(n_cyc), 32'h0);
    hit(0, 1'b0);
    hit(1, 1'b0);
    wt(110);
    rd_reg(BISG_A_STAT, v);
    chk("window closed", 32'(v[2]), 32'h0);
    hit(0, 1'b1);
    hit(1, 1'b1);
    chk("after window ch0", 32'({n_req[0], 7'h0, last_val[0]}), 32'h101);
    chk("after window ch1", 32'(n_req[1]), 32'h1);
    pulse_tick();
    chk("cyclic after", 32'(n_cyc), 32'h0101);
    hit(0, 1'b0);
    hit(1, 1'b0);
    // Bus return, delay of 240 cycles beyond the window
    wr_reg(BISG_A_DELAY, 32'h3C);
    wr_reg(BISG_A_CH1, 32'h63);
    clear();
    @(posedge clk);
    bus_ret <= 1'b1;
    wt(4);
    bus_ret <= 1'b0;
    wt(200);
    chk("shared delay wait", 32'(n_req), 32'h0);
    wt(60);
    chk("both returned", 32'(n_req), 32'h0101);
    chk("return values", 32'(last_val), 32'h3);
    summarize();
  end
endmodule // bisg_top_tb_top
